/* File: crf_map.svh */
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

`define CRF_TYPE_EXT_BIT      7
`define CRF_TYPE_FILT_COLOUR  7'h10
`define CRF_TAG_STREAM_LSB    0
`define CRF_TAG_STREAM_W      6
`define CRF_TAG_MATCH_LSB     6
`define CRF_TAG_MATCH_W       8
`define CRF_TAG_CRC_BIT       14
`define CRF_TAG_PAR_BIT       15
`define CRF_BASE_HDR_BYTES    16
`define CRF_EXT_HDR_BYTES     8
`define CRF_OFFSET_PAD_BYTES  2
`define CRF_ETH_HDR_BYTES     18
`define CRF_SNAP_ALIGN        8
`define CRF_TAG_POS           10
`define CRF_TYPE_POS          8
`define CRF_OFFSET_FILL       8'h00
`define CRF_PAD_FILL          8'h00

`endif

/* File: crf_pkg.sv */
`default_nettype none
package crf_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } crf_byte_t;

  typedef struct packed {
    logic [5:0] stream;
    logic [7:0] match;
    logic       crc_hash_bit;
    logic       parity_hash_bit;
  } crf_class_t;

  typedef enum logic [2:0] {
    CRF_IDLE = 3'b000,
    CRF_BASE = 3'b001,
    CRF_EXT  = 3'b011,
    CRF_OFFS = 3'b010,
    CRF_PAD  = 3'b110,
    CRF_PAY  = 3'b111
  } crf_state_t;
endpackage
`default_nettype wire

/* File: crf_colour_tag.sv */
`include "crf_map.svh"
`default_nettype none
module crf_colour_tag (
  // Classification in
  input  wire crf_pkg::crf_class_t cls,
  // Packed tag out
  output logic [15:0]              tag
);
  import crf_pkg::*;

  assign tag[`CRF_TAG_STREAM_LSB +: `CRF_TAG_STREAM_W] = cls.stream;
  genvar i;
  generate
    for (i = 0; i < `CRF_TAG_MATCH_W; i++) begin : g_match
      assign tag[`CRF_TAG_MATCH_LSB + i] = cls.match[i];
    end
  endgenerate
  assign tag[`CRF_TAG_CRC_BIT] = cls.crc_hash_bit;
  assign tag[`CRF_TAG_PAR_BIT] = cls.parity_hash_bit;
endmodule
`default_nettype wire

/* File: crf_formatter.sv */
// Overview of operation
// - Record type bit 7 is one exactly when an extension header follows.
// - The low seven type bits carry the value 16 for this record.
// - A 2-byte hardware colour tag replaces the loss counter field.
// - Tag bits 0 to 5 carry the receive stream number.
// - Tag bits 6 to 13 carry filter match flags, bit 6 for filter zero.
// - Tag bit 14 carries the CRC hash output bit.
// - Tag bit 15 carries the parity hash output bit.
// - The offset byte is not implemented and the host ignores it.
// - One pad byte is emitted and the frame starts right after it.
// - Payload is record length less 16, less extension headers, less 2.
// - Payload delivered is at most the snap length less two bytes.
// - Each extension header type bit 7 is one when another header follows.
// - Every extension header is exactly eight bytes long.
// - Each extension header type field states its own kind and layout.
`include "crf_map.svh"
`default_nettype none
module crf_formatter #(
  parameter int MAX_EXT  = 4,
  parameter int SNAP_W   = 16
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Configuration
  input  wire logic [SNAP_W-1:0]       snap_len,
  // Record start request
  input  wire logic                    start,
  output logic                         start_ready,
  input  wire logic [95:0]             base_fields,
  input  wire crf_pkg::crf_class_t     cls,
  input  wire logic [2:0]              ext_count,
  input  wire logic [MAX_EXT*7-1:0]    ext_type,
  input  wire logic [MAX_EXT*56-1:0]   ext_body,
  // Frame bytes in
  input  wire crf_pkg::crf_byte_t      frame_in,
  input  wire logic                    frame_valid,
  output logic                         frame_ready,
  // Record bytes out
  output crf_pkg::crf_byte_t           rec_out,
  output logic                         rec_valid,
  input  wire logic                    rec_ready,
  // Status
  output logic                         busy,
  output logic                         truncated
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The header index and the header count are three bits wide.
  if (MAX_EXT < 1 || MAX_EXT > 7) begin : g_bad_max_ext
    $error("MAX_EXT must be 1..7");
  end
  // The payload counter must be able to hold a whole snap length.
  if (SNAP_W < 5) begin : g_bad_snap_w
    $error("SNAP_W too small");
  end

  crf_state_t         state;
  crf_state_t         next_state;
  logic [3:0]         cnt;
  logic [2:0]         ext_idx;
  logic [SNAP_W-1:0]  pay_cnt;
  logic [2:0]         n_ext;
  logic [95:0]        base_q;
  logic [15:0]        tag_q;
  logic [MAX_EXT*7-1:0]  ext_type_q;
  logic [MAX_EXT*56-1:0] ext_body_q;
  logic [15:0]        tag_w;
  logic               drop;

  // ----------------------------------------------------------------
  // Colour tag
  // ----------------------------------------------------------------
  crf_colour_tag u_tag (
    .cls (cls),
    .tag (tag_w)
  );

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  wire        out_fire  = rec_valid && rec_ready;
  wire        last_ext  = (ext_idx == n_ext - 3'd1);
  wire [7:0]  type_byte = {(n_ext != 3'd0), `CRF_TYPE_FILT_COLOUR};
  wire [7:0]  ext_tbyte = {!last_ext, ext_type_q[ext_idx*7 +: 7]};
  wire [7:0]  ext_bbyte = ext_body_q[ext_idx*56 + (cnt - 4'd1)*8 +: 8];
  wire [7:0]  base_byte = (cnt == 4'(`CRF_TYPE_POS)) ? type_byte :
                          (cnt == `CRF_TAG_POS)      ? tag_q[15:8] :
                          (cnt == `CRF_TAG_POS + 1)  ? tag_q[7:0] :
                          base_q[95 - (cnt - ((cnt > 4'(`CRF_TYPE_POS)) ? 4'd4 : 4'd0))*8 -: 8];
  // payload limit is snap less header extra
  wire [SNAP_W-1:0] pay_lim = snap_len - SNAP_W'(`CRF_OFFSET_PAD_BYTES);
  wire        pay_full  = (pay_cnt >= pay_lim);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign start_ready = (state == CRF_IDLE);
  assign busy        = (state != CRF_IDLE);
  assign frame_ready = (state == CRF_PAY) && (drop || rec_ready);
  assign rec_valid   = (state == CRF_PAY) ? (frame_valid && !drop) :
                       (state != CRF_IDLE);

  always_comb begin
    rec_out.last = 1'b0;
    case (state)
      CRF_BASE: rec_out.data = base_byte;
      CRF_EXT:  rec_out.data = (cnt == 4'd0) ? ext_tbyte : ext_bbyte;
      CRF_OFFS: rec_out.data = `CRF_OFFSET_FILL;
      CRF_PAD:  rec_out.data = `CRF_PAD_FILL;
      CRF_PAY: begin
        rec_out.data = frame_in.data;
        rec_out.last = frame_in.last || (pay_cnt + 1'b1 >= pay_lim);
      end
      default:  rec_out.data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire cnt_end_base = (cnt == 4'(`CRF_BASE_HDR_BYTES - 1));
  wire cnt_end_ext  = (cnt == 4'(`CRF_EXT_HDR_BYTES - 1));
  wire pay_done     = frame_valid && frame_ready &&
                      (frame_in.last || (!drop && pay_cnt + 1'b1 >= pay_lim));

  always_comb begin
    next_state = state;
    case (state)
      CRF_IDLE: if (start) next_state = CRF_BASE;
      CRF_BASE: if (out_fire && cnt_end_base) begin
        next_state = (n_ext != 3'd0) ? CRF_EXT : CRF_OFFS;
      end
      CRF_EXT:  if (out_fire && cnt_end_ext && last_ext) next_state = CRF_OFFS;
      CRF_OFFS: if (out_fire) next_state = CRF_PAD;
      CRF_PAD:  if (out_fire) next_state = CRF_PAY;
      CRF_PAY:  if (pay_done && frame_in.last) next_state = CRF_IDLE;
      default:  next_state = CRF_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CRF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Byte and header counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt     <= 4'h0;
      ext_idx <= 3'h0;
    end else if (state == CRF_IDLE || (out_fire && (cnt_end_base && state == CRF_BASE))) begin
      cnt     <= 4'h0;
      ext_idx <= 3'h0;
    end else if (out_fire && state == CRF_EXT) begin
      cnt     <= cnt_end_ext ? 4'h0 : cnt + 4'h1;
      ext_idx <= cnt_end_ext ? ext_idx + 3'h1 : ext_idx;
    end else if (out_fire && state == CRF_BASE) begin
      cnt     <= cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Record capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n_ext      <= 3'h0;
      base_q     <= '0;
      tag_q      <= 16'h0000;
      ext_type_q <= '0;
      ext_body_q <= '0;
    end else if (state == CRF_IDLE && start) begin
      n_ext      <= (ext_count > 3'(MAX_EXT)) ? 3'(MAX_EXT) : ext_count;
      base_q     <= base_fields;
      tag_q      <= tag_w;
      ext_type_q <= ext_type;
      ext_body_q <= ext_body;
    end
  end

  // ----------------------------------------------------------------
  // Payload accounting
  // ----------------------------------------------------------------
  // Excess frame bytes beyond the snap limit are drained without output.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pay_cnt   <= '0;
      drop      <= 1'b0;
      truncated <= 1'b0;
    end else if (state == CRF_IDLE) begin
      pay_cnt   <= '0;
      drop      <= 1'b0;
      if (start) truncated <= 1'b0;
    end else if (state == CRF_PAY && frame_valid && frame_ready) begin
      pay_cnt <= pay_full ? pay_cnt : pay_cnt + 1'b1;
      if (!drop && pay_cnt + 1'b1 >= pay_lim && !frame_in.last) begin
        drop      <= 1'b1;
        truncated <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: crf_formatter_properties.sv */
`default_nettype none
module crf_formatter_properties #(
  parameter int MAX_EXT = 4,
  parameter int SNAP_W  = 16
) (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic [SNAP_W-1:0]    snap_len,
  input wire logic                 start,
  input wire logic                 start_ready,
  input wire crf_pkg::crf_class_t  cls,
  input wire logic [2:0]           ext_count,
  input wire logic [MAX_EXT*7-1:0] ext_type,
  input wire crf_pkg::crf_byte_t   rec_out,
  input wire logic                 rec_valid,
  input wire logic                 rec_ready,
  input wire logic                 busy
);
  import crf_pkg::*;
  logic [15:0]          cnt;
  logic [2:0]           n;
  crf_class_t           c;
  logic [MAX_EXT*7-1:0] ty;
  wire         go = start && start_ready;
  wire [15:0]  hs = 16'd18 + 16'(n) * 16'd8;
  wire [15:0]  k  = (cnt - 16'd16) >> 3;
  // Byte index within the record and the fields captured at its start.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      n <= '0;
      c <= '0;
      ty <= '0;
    end else if (go) begin
      cnt <= '0;
      n <= (ext_count > 3'(MAX_EXT)) ? 3'(MAX_EXT) : ext_count;
      c <= cls;
      ty <= ext_type;
    end else if (rec_valid && rec_ready) begin
      cnt <= cnt + 16'd1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_off;
    rec_valid && rec_out.data == 8'h00;
  endsequence
  sequence s_pad;
    rec_valid && cnt == hs - 16'd1 && rec_out.data == 8'h00;
  endsequence
  property p_ext_flag;
    rec_valid && cnt == 16'd8 |-> rec_out.data[7] == (n != 3'd0);
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("type flag wrong");
  property p_type;
    rec_valid && cnt == 16'd8 |-> rec_out.data[6:0] == 7'h10;
  endproperty
  a_type: assert property (p_type) else $error("type code wrong");
  property p_tag_hi;
    rec_valid && cnt == 16'd10 |-> rec_out.data == {c.parity_hash_bit, c.crc_hash_bit,
      c.match[7:2]};
  endproperty
  a_tag_hi: assert property (p_tag_hi) else $error("tag high wrong");
  property p_tag_lo;
    rec_valid && cnt == 16'd11 |-> rec_out.data == {c.match[1:0], c.stream};
  endproperty
  a_tag_lo: assert property (p_tag_lo) else $error("tag low wrong");
  property p_ext_hdr;
    rec_valid && cnt >= 16'd16 && cnt < hs - 16'd2 && cnt[2:0] == 3'd0 |->
      rec_out.data == {k != 16'(n) - 16'd1, ty[k*7 +: 7]};
  endproperty
  a_ext_hdr: assert property (p_ext_hdr) else $error("ext type wrong");
  property p_off_pad;
    rec_valid && rec_ready && cnt == hs - 16'd2 |-> s_off ##1 s_pad;
  endproperty
  a_off_pad: assert property (p_off_pad) else $error("offset or pad wrong");
  property p_snap;
    rec_valid && rec_out.last |-> cnt >= hs && cnt - hs < 16'(snap_len) - 16'd2;
  endproperty
  a_snap: assert property (p_snap) else $error("payload too long");
  property p_hold;
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_answer;
    go |=> busy && rec_valid && !start_ready;
  endproperty
  a_answer: assert property (p_answer) else $error("record not started");
endmodule
bind crf_formatter crf_formatter_properties #(.MAX_EXT(MAX_EXT), .SNAP_W(SNAP_W))
  crf_formatter_properties_inst (.clk(clk), .rstn(rstn), .snap_len(snap_len),
  .start(start), .start_ready(start_ready), .cls(cls), .ext_count(ext_count),
  .ext_type(ext_type), .rec_out(rec_out), .rec_valid(rec_valid),
  .rec_ready(rec_ready), .busy(busy));
`default_nettype wire

/* File: crf_host_sink.sv */
`default_nettype none
module crf_host_sink (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               slow,
  input  wire crf_pkg::crf_byte_t rec_out,
  input  wire logic               rec_valid,
  output logic                    rec_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import crf_pkg::*;
  logic [7:0] mem [0:1023];
  int         n;
  int         last_n;
  logic       tog;
  // A slow host accepts only every other cycle.
  assign rec_ready = !slow || tog;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n <= 0;
      last_n <= 0;
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      if (rec_valid && rec_ready) begin
        mem[n] <= rec_out.data;
        n <= n + 1;
        if (rec_out.last) last_n <= n;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_capture_record_formatter.sv */
`default_nettype none
module tb_capture_record_formatter;
  timeunit 1ns;
  timeprecision 1ns;
  import crf_pkg::*;
  logic       clk, rstn, start, slow;
  logic       frame_valid = 1'b0;
  logic [15:0] snap_len;
  logic [2:0] ext_count;
  logic [7:0] flen = 8'h00;
  logic [7:0] fidx = 8'h00;
  crf_class_t cls;
  crf_byte_t  frame_in = '0;
  crf_byte_t  rec_out;
  logic       start_ready, frame_ready, rec_valid, rec_ready, busy, truncated;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  crf_formatter #(.MAX_EXT(4), .SNAP_W(16)) crf_formatter_inst (.clk(clk), .rstn(rstn),
    .snap_len(snap_len), .start(start), .start_ready(start_ready),
    .base_fields(96'h0123456789ABCDEF02468ACE), .cls(cls), .ext_count(ext_count),
    .ext_type(28'h1234567), .ext_body({7{32'hC0FFEE11}}), .frame_in(frame_in),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .rec_out(rec_out),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .busy(busy), .truncated(truncated));
  crf_host_sink crf_host_sink_inst (.clk(clk), .rstn(rstn), .slow(slow),
    .rec_out(rec_out), .rec_valid(rec_valid), .rec_ready(rec_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      stop_test();
    end
  end
  always @(posedge clk) begin
    if (start && start_ready) fidx <= 8'h00;
    else if (frame_valid && frame_ready) fidx <= fidx + 8'h01;
  end
  always @(negedge clk) begin
    frame_valid <= busy && fidx < flen;
    frame_in <= {8'hA0 + fidx, fidx == flen - 8'h01};
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [2:0] n, input logic [7:0] fl, input logic [15:0] sl,
                     input logic sw, input crf_class_t c);
    int b, pl, i;
    logic [15:0] et, got;
    b = crf_host_sink_inst.n;
    pl = (fl < sl - 16'd2) ? fl : sl - 16'd2;
    ext_count = n;
    flen = fl;
    snap_len = sl;
    slow = sw;
    cls = c;
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    for (i = 0; i < 800 && busy !== 1'b0; i++) @(negedge clk);
    chk("len", 16'(18 + 8 * n + pl), 16'(crf_host_sink_inst.n - b));
    chk("type", {8'h00, n != 3'd0, 7'h10}, 16'(crf_host_sink_inst.mem[b + 8]));
    et = {c.parity_hash_bit, c.crc_hash_bit, c.match, c.stream};
    got = {crf_host_sink_inst.mem[b + 10], crf_host_sink_inst.mem[b + 11]};
    chk("tag", et, got);
    got = 16'(crf_host_sink_inst.mem[b + 16]);
    if (n != 3'd0) chk("ext", {8'h00, n > 3'd1, 7'h67}, got);
    got = 16'(crf_host_sink_inst.mem[b + 17]);
    if (n != 3'd0) chk("ebody", 16'h0011, got);
    chk("offset", 16'h0000, 16'(crf_host_sink_inst.mem[b + 16 + 8 * n]));
    chk("pad", 16'h0000, 16'(crf_host_sink_inst.mem[b + 17 + 8 * n]));
    chk("pay", 16'(8'hA0 + pl - 1), 16'(crf_host_sink_inst.mem[b + 17 + 8 * n + pl]));
    chk("last", 16'(17 + 8 * n + pl), 16'(crf_host_sink_inst.last_n - b));
    chk("trunc", 16'(fl > pl), 16'(truncated));
  endtask
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    snap_len = 16'd64;
    ext_count = 3'd0;
    cls = '0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    run(3'd0, 8'd20, 16'd64, 1'b0, {6'h3F, 8'h01, 1'b0, 1'b1});
    run(3'd1, 8'd60, 16'd48, 1'b1, {6'h00, 8'h80, 1'b1, 1'b0});
    run(3'd4, 8'd1, 16'd8, 1'b1, {6'h15, 8'hA5, 1'b1, 1'b1});
    run(3'd2, 8'd14, 16'd16, 1'b0, {6'h2A, 8'h5A, 1'b0, 1'b0});
    stop_test();
  end
endmodule
`default_nettype wire
